// [src/swt_top.sv]
// Added by the designer: the register addresses and the APB slave port.
`include "swt_params.svh"
`default_nettype none
// Behaviour
// - command code 78h written first selects the triplet
// - one parameter byte; only bit 7 is the direction, rest ignored
// - each accepted triplet makes two read slots then one write slot
// - reads 0,0: write slot follows the direction bit
// - reads 0,1: write-0 slot regardless of direction
// - reads 1,0: write-1 slot regardless of direction
// - reads 1,1 error case: still a write-1 slot
// - command while busy is refused and discarded
// - whole triplet ends within three slots plus 262.5 ns
// - line activity starts within 262.5 ns of the command
// - accepting points the read pointer at the status register
// - busy flag held for exactly three slot periods, then cleared
// - first read flag updated at first sample instant
// - second read and direction flags updated at second sample instant
module swt_top #(
  parameter int SLOT_STD_CYC = (`SWT_SLOT_STD_NS * 1000 + `SWT_CLK_PERIOD_PS - 1) / `SWT_CLK_PERIOD_PS,
  parameter int W0_STD_CYC = (`SWT_W0_STD_NS * 1000 + `SWT_CLK_PERIOD_PS - 1) / `SWT_CLK_PERIOD_PS
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // single-wire line, open drain
  input wire logic line_in,
  output logic line_out,
  output logic line_oe,
  // interrupt
  output logic irq
);
  import swt_pkg::*;
  localparam int START_MAX_CYC = `SWT_START_MAX_PS / `SWT_CLK_PERIOD_PS;
  localparam int SLOT_OD_CYC = (`SWT_SLOT_OD_NS * 1000 + `SWT_CLK_PERIOD_PS - 1) / `SWT_CLK_PERIOD_PS;

  logic line_meta;
  logic line_sync;
  logic access;
  logic wr;
  logic hit;
  logic cmd_wr;
  logic accept;
  logic refuse;
  logic v_bit;
  logic busy;
  logic [1:0] read_ptr;
  logic [1:0] int_status;
  logic [1:0] int_enable;
  logic [1:0] int_set;
  logic [1:0] int_clr;
  logic [1:0] next_int_status;
  logic [1:0] next_int_enable;
  logic [31:0] next_rdata;
  logic slot_start;
  logic slot_write_bit;
  logic sample_pulse;
  logic sample_bit;
  logic slot_done;
  logic first_rd;
  logic second_rd;
  logic dir;
  swt_cfg_t cfg;
  swt_cfg_t cfg_lat;
  swt_status_t status;
  swt_seq_t state;
  swt_seq_t next_state;
  swt_line_drv_t drv;

  // line pin comes from outside the clock domain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_meta <= 1'b1;
      line_sync <= 1'b1;
    end else begin
      line_meta <= line_in;
      line_sync <= line_meta;
    end
  end

  // apb decode; zero wait states, unmapped offsets answer with an error
  assign access = psel && penable;
  assign wr = access && pwrite;
  assign pready = 1'b1;
  assign pslverr = access && !hit;
  always_comb begin
    case (paddr)
      `SWT_REG_CMD, `SWT_REG_STATUS, `SWT_REG_CONFIG, `SWT_REG_READ_PTR,
      `SWT_REG_READ_DATA, `SWT_REG_INT_STATUS, `SWT_REG_INT_ENABLE, `SWT_REG_INT_CLEAR: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // command acceptance: right code and an idle sequencer, else refused with the refused interrupt
  assign cmd_wr = wr && (paddr == `SWT_REG_CMD);
  assign accept = cmd_wr && !busy && (pwdata[`SWT_CMD_CODE_LSB +: 8] == `SWT_CMD_TRIPLET);
  assign refuse = cmd_wr && !accept;
  assign busy = (state != SEQ_IDLE);

  // direction bit and slot settings taken at acceptance, so mid-run config writes wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      v_bit <= 1'b0;
      cfg_lat <= '0;
    end else if (accept) begin
      v_bit <= pwdata[`SWT_CMD_PARAM_LSB + `SWT_DIR_BIT];
      cfg_lat <= cfg;
    end
  end

  // configuration register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= '0;
    end else if (wr && paddr == `SWT_REG_CONFIG) begin
      cfg <= swt_cfg_t'({6'h00, pwdata[1:0]});
    end
  end

  // read pointer; an accepted triplet aims it at the status register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_ptr <= `SWT_PTR_STATUS;
    end else if (accept) begin
      read_ptr <= `SWT_PTR_STATUS;
    end else if (wr && paddr == `SWT_REG_READ_PTR) begin
      read_ptr <= pwdata[1:0];
    end
  end

  // sequencer: read, read, write, with slots back to back
  always_comb begin
    next_state = state;
    case (state)
      SEQ_IDLE: begin
        if (accept) begin
          next_state = SEQ_READ1;
        end
      end
      SEQ_READ1: begin
        if (slot_done) begin
          next_state = SEQ_READ2;
        end
      end
      SEQ_READ2: begin
        if (slot_done) begin
          next_state = SEQ_WRITE;
        end
      end
      SEQ_WRITE: begin
        if (slot_done) begin
          next_state = SEQ_IDLE;
        end
      end
      default: next_state = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= SEQ_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // first slot starts on the accepting edge itself, well inside the latency bound
  assign slot_start = accept || (slot_done && (state == SEQ_READ1 || state == SEQ_READ2));
  assign slot_write_bit = (state == SEQ_READ2) ? dir : 1'b1;

  swt_slot_gen #(
    .SLOT_STD_CYC(SLOT_STD_CYC),
    .W0_STD_CYC(W0_STD_CYC)
  ) u_slot (
    .pclk(pclk),
    .presetn(presetn),
    .start(slot_start),
    .write_bit(slot_write_bit),
    .cfg(cfg_lat),
    .line_sync(line_sync),
    .drv(drv),
    .sample_pulse(sample_pulse),
    .sample_bit(sample_bit),
    .done(slot_done)
  );
  assign line_out = drv.line_out;
  assign line_oe = drv.line_oe;

  // read flags and branch choice at the sample instants
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_rd <= 1'b0;
      second_rd <= 1'b0;
      dir <= 1'b0;
    end else if (sample_pulse && state == SEQ_READ1) begin
      first_rd <= sample_bit;
    end else if (sample_pulse && state == SEQ_READ2) begin
      second_rd <= sample_bit;
      // differing reads force the branch, equal reads take v except 1,1
      if (first_rd != sample_bit) begin
        dir <= first_rd;
      end else begin
        dir <= first_rd | v_bit;
      end
    end
  end

  always_comb begin
    status = '0;
    status.busy = busy;
    status.first_rd = first_rd;
    status.second_rd = second_rd;
    status.dir = dir;
  end

  // interrupt events; a set in the clearing cycle wins
  always_comb begin
    int_set = 2'h0;
    int_set[`SWT_INT_DONE] = slot_done && state == SEQ_WRITE;
    int_set[`SWT_INT_REFUSED] = refuse;
    int_clr = (wr && paddr == `SWT_REG_INT_CLEAR) ? pwdata[1:0] : 2'h0;
    next_int_status = (int_status & ~int_clr) | int_set;
    next_int_enable = (wr && paddr == `SWT_REG_INT_ENABLE) ? pwdata[1:0] : int_enable;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status <= 2'h0;
      int_enable <= 2'h0;
      irq <= 1'b0;
    end else begin
      int_status <= next_int_status;
      int_enable <= next_int_enable;
      // built from next values so irq never lags an enable write
      irq <= |(next_int_status & next_int_enable);
    end
  end

  // read data captured in the setup cycle so it stands through the access
  always_comb begin
    case (paddr)
      `SWT_REG_STATUS: next_rdata = {24'h000000, status};
      `SWT_REG_CONFIG: next_rdata = {24'h000000, cfg};
      `SWT_REG_READ_PTR: next_rdata = {30'h00000000, read_ptr};
      `SWT_REG_READ_DATA: next_rdata = (read_ptr == `SWT_PTR_CONFIG) ? {24'h000000, cfg} : {24'h000000, status};
      `SWT_REG_INT_STATUS: next_rdata = {30'h00000000, int_status};
      `SWT_REG_INT_ENABLE: next_rdata = {30'h00000000, int_enable};
      default: next_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_rdata;
    end
  end

  // helper: cycles spent busy in the current run
  logic [19:0] busy_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_cnt <= 20'h00000;
    end else if (busy) begin
      busy_cnt <= busy_cnt + 20'h00001;
    end else begin
      busy_cnt <= 20'h00000;
    end
  end

  // helper: slots opened in the current run
  logic [1:0] slot_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_cnt <= 2'h0;
    end else if (accept) begin
      slot_cnt <= 2'h1;
    end else if (slot_start) begin
      slot_cnt <= slot_cnt + 2'h1;
    end
  end

  a_accept_busy: assert property (@(posedge pclk) disable iff (!presetn)
    accept |=> busy && state == SEQ_READ1)
    else $error("accepted triplet did not start the first read slot");

  a_refuse_discard: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_wr && busy) |=> int_status[`SWT_INT_REFUSED] && state == $past(state) || $past(slot_done))
    else $error("command during busy was not refused");

  a_wrong_code: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_wr && !busy && pwdata[7:0] != `SWT_CMD_TRIPLET) |=> !busy)
    else $error("non-triplet code started a sequence");

  a_start_latency: assert property (@(posedge pclk) disable iff (!presetn)
    accept |-> ##[1:START_MAX_CYC] (line_oe && !line_out))
    else $error("line activity started too late");

  a_busy_length: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(busy) |-> $past(busy_cnt) == 20'((cfg_lat.speed ? SLOT_OD_CYC : SLOT_STD_CYC) * 3 - 1))
    else $error("busy did not last three slot periods");

  a_ptr_status: assert property (@(posedge pclk) disable iff (!presetn)
    accept |=> read_ptr == `SWT_PTR_STATUS)
    else $error("read pointer not at status after accept");

  a_first_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (sample_pulse && state == SEQ_READ1) |=> first_rd == $past(sample_bit) && second_rd == $past(second_rd))
    else $error("first read flag not taken at first sample");

  a_branch_dir: assert property (@(posedge pclk) disable iff (!presetn)
    (sample_pulse && state == SEQ_READ2) |=>
      dir == (($past(first_rd) ^ $past(sample_bit)) ? $past(first_rd) : ($past(first_rd) | v_bit)))
    else $error("branch direction wrong after second sample");

  a_write_slot: assert property (@(posedge pclk) disable iff (!presetn)
    (slot_done && state == SEQ_READ2) |-> slot_start && slot_write_bit == (first_rd | (!second_rd && v_bit)))
    else $error("third slot does not write the branch direction");

  a_second_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (sample_pulse && state == SEQ_READ2) |=> second_rd == $past(sample_bit) && first_rd == $past(first_rd))
    else $error("second read flag not taken at second sample");

  a_done_bound: assert property (@(posedge pclk) disable iff (!presetn)
    busy |-> busy_cnt <= 20'((cfg_lat.speed ? SLOT_OD_CYC : SLOT_STD_CYC) * 3 + START_MAX_CYC))
    else $error("triplet ran past three slots plus start latency");

  a_slot_count: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(busy) |-> slot_cnt == 2'h3)
    else $error("triplet did not open exactly three slots");

  a_apu_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !cfg_lat.active_pullup_enable |-> !(line_oe && line_out))
    else $error("line driven high with active pullup off");

  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    irq == |(int_status & int_enable))
    else $error("interrupt output does not follow enabled status");
endmodule
`default_nettype wire

// [src/swt_params.svh]
`ifndef SWT_PARAMS_SVH
`define SWT_PARAMS_SVH
// apb register byte offsets
`define SWT_REG_CMD 8'h00
`define SWT_REG_STATUS 8'h04
`define SWT_REG_CONFIG 8'h08
`define SWT_REG_READ_PTR 8'h0c
`define SWT_REG_READ_DATA 8'h10
`define SWT_REG_INT_STATUS 8'h14
`define SWT_REG_INT_ENABLE 8'h18
`define SWT_REG_INT_CLEAR 8'h1c
// command word layout: code in the low byte, direction byte above it
`define SWT_CMD_TRIPLET 8'h78
`define SWT_CMD_CODE_LSB 0
`define SWT_CMD_PARAM_LSB 8
`define SWT_DIR_BIT 7
// read pointer selections
`define SWT_PTR_STATUS 2'h0
`define SWT_PTR_CONFIG 2'h1
// interrupt bit positions
`define SWT_INT_DONE 0
`define SWT_INT_REFUSED 1
// timing, clock period and start latency in ps, slot figures in ns
`define SWT_CLK_PERIOD_PS 4000
`define SWT_START_MAX_PS 262500
`define SWT_SLOT_STD_NS 70000
`define SWT_SLOT_OD_NS 10000
`define SWT_W0_STD_NS 60000
`define SWT_W0_OD_NS 7500
`define SWT_W1_STD_NS 6000
`define SWT_W1_OD_NS 1000
`define SWT_MSR_STD_NS 15000
`define SWT_MSR_OD_NS 2000
`define SWT_APU_NS 1000
`endif

// [src/swt_pkg.sv]
`default_nettype none
package swt_pkg;
  // status register layout
  typedef struct packed {
    logic dir;
    logic second_rd;
    logic first_rd;
    logic [3:0] rsvd;
    logic busy;
  } swt_status_t;
  // configuration register layout
  typedef struct packed {
    logic [5:0] rsvd;
    logic active_pullup_enable;
    logic speed;
  } swt_cfg_t;
  // open-drain line drive pair
  typedef struct packed {
    logic line_out;
    logic line_oe;
  } swt_line_drv_t;
  // triplet sequencer states
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_READ1, SEQ_READ2, SEQ_WRITE} swt_seq_t;
endpackage
`default_nettype wire

// [src/swt_slot_gen.sv]
`include "swt_params.svh"
`default_nettype none
module swt_slot_gen #(
  parameter int SLOT_STD_CYC = (`SWT_SLOT_STD_NS * 1000 + `SWT_CLK_PERIOD_PS - 1) / `SWT_CLK_PERIOD_PS,
  parameter int W0_STD_CYC = (`SWT_W0_STD_NS * 1000 + `SWT_CLK_PERIOD_PS - 1) / `SWT_CLK_PERIOD_PS
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // slot request
  input wire logic start,
  input wire logic write_bit,
  input wire swt_pkg::swt_cfg_t cfg,
  // line
  input wire logic line_sync,
  output var swt_pkg::swt_line_drv_t drv,
  // results
  output logic sample_pulse,
  output logic sample_bit,
  output logic done
);
  import swt_pkg::*;
  localparam int P = `SWT_CLK_PERIOD_PS;
  localparam int SLOT_OD = (`SWT_SLOT_OD_NS * 1000 + P - 1) / P;
  localparam int W0_OD = (`SWT_W0_OD_NS * 1000 + P - 1) / P;
  localparam int W1_STD = (`SWT_W1_STD_NS * 1000 + P - 1) / P;
  localparam int W1_OD = (`SWT_W1_OD_NS * 1000 + P - 1) / P;
  localparam int MSR_STD = `SWT_MSR_STD_NS * 1000 / P;
  localparam int MSR_OD = `SWT_MSR_OD_NS * 1000 / P;
  localparam int APU_CYC = (`SWT_APU_NS * 1000 + P - 1) / P;

  logic active;
  logic wbit;
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic [15:0] slot_len;
  logic [15:0] low_len;
  logic [15:0] msr_len;
  logic [15:0] apu_end;

  // speed picks every length but the active pullup pulse; a read slot is a write-1 slot
  always_comb begin
    slot_len = cfg.speed ? 16'(SLOT_OD) : 16'(SLOT_STD_CYC);
    msr_len = cfg.speed ? 16'(MSR_OD) : 16'(MSR_STD);
    if (wbit) begin
      low_len = cfg.speed ? 16'(W1_OD) : 16'(W1_STD);
    end else begin
      low_len = cfg.speed ? 16'(W0_OD) : 16'(W0_STD_CYC);
    end
    apu_end = low_len + 16'(APU_CYC);
    next_cnt = cnt + 16'h0001;
  end

  assign done = active && (cnt == slot_len - 16'h0001);

  // slot counter and line drive; every slot opens with a low pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active <= 1'b0;
      wbit <= 1'b0;
      cnt <= 16'h0000;
      drv <= '0;
    end else if (start) begin
      active <= 1'b1;
      wbit <= write_bit;
      cnt <= 16'h0000;
      drv.line_out <= 1'b0;
      drv.line_oe <= 1'b1;
    end else if (active) begin
      if (done) begin
        active <= 1'b0;
        drv <= '0;
      end else begin
        cnt <= next_cnt;
        drv.line_out <= !(next_cnt < low_len);
        // active pullup only once the line is seen high, so no fight with a slave
        drv.line_oe <= (next_cnt < low_len) || (cfg.active_pullup_enable && line_sync && next_cnt < apu_end);
      end
    end
  end

  // master sample instant
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_pulse <= 1'b0;
      sample_bit <= 1'b0;
    end else begin
      sample_pulse <= active && !start && (cnt == msr_len - 16'h0001);
      sample_bit <= line_sync;
    end
  end
endmodule
`default_nettype wire

// [dv/swt_line_slave.sv]
`default_nettype none
// behavioural slave on the single-wire line, released line floats to the pull-up
module swt_line_slave (
  // control
  input wire logic presetn,
  input wire logic [1:0] answer,
  // line
  input wire logic line,
  output logic pull_low,
  // observed write slots
  output logic last_write,
  output var int write_count
);
  timeunit 1ns;
  timeprecision 1ps;
  int slot_idx;
  realtime t_fall;
  initial begin
    pull_low = 1'b0;
    last_write = 1'b0;
    write_count = 0;
    slot_idx = 0;
    t_fall = 0;
  end
  // read slots: a zero is held well past the master sample point
  always @(negedge line) begin
    t_fall = $realtime;
    if (presetn && slot_idx < 2 && !answer[slot_idx]) begin
      pull_low = 1'b1;
      #2400;
      pull_low = 1'b0;
    end
  end
  // a slot ends on release; a long low in slot three is a written zero
  always @(posedge line) begin
    if (presetn && slot_idx == 2) begin
      last_write = ($realtime - t_fall) < 4000.0;
      write_count++;
    end
    slot_idx = (!presetn || slot_idx == 2) ? 0 : slot_idx + 1;
  end
  // reset forgets a half-seen triplet
  always @(negedge presetn) slot_idx = 0;
endmodule
`default_nettype wire

// [dv/tb_single_wire_search_triplet.sv]
`include "swt_params.svh"
`default_nettype none
module tb_single_wire_search_triplet;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, line_out, line_oe, irq;
  logic pull_low, last_write, apu_seen, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [1:0] answer;
  // answer bit 0 is the first read slot, bit 1 the second
  logic [1:0] tab_ans [5] = '{2'b00, 2'b00, 2'b10, 2'b01, 2'b11};
  int write_count, err_count, samples_checked, cyc, t0, accepted;
  // open-drain wire: any low driver wins, otherwise pulled up
  wire logic line_wire = (pull_low || (line_oe && !line_out)) ? 1'b0 : 1'b1;
  swt_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_in(line_wire), .line_out(line_out), .line_oe(line_oe), .irq(irq));
  swt_line_slave slave_u (.presetn(presetn), .answer(answer), .line(line_wire), .pull_low(pull_low),
    .last_write(last_write), .write_count(write_count));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // cycle count, active pull-up watch and hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (line_oe && line_out) apu_seen <= 1'b1;
    if (cyc == 50000) begin
      err_count++;
      results();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer, called just after a rising edge; ends one idle edge later
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: a slave that never answers runs into the bench timeout
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic logic exp_dir(input logic [1:0] ans, input logic v);
    return ans[0] ? 1'b1 : (ans[1] ? 1'b0 : v);
  endfunction
  // one triplet with chosen slave answers, direction, pull-up and interrupt mask
  task automatic run_trip(input int idx, input logic [1:0] ans, input logic v, input logic active_pullup_enable, input logic ien);
    logic [7:0] dbyte;
    dbyte = {v, 7'($urandom)};
    answer <= ans;
    apb(1'b1, `SWT_REG_CONFIG, {30'h0, active_pullup_enable, 1'b1}, q, e);
    apb(1'b1, `SWT_REG_INT_ENABLE, {31'h0, ien}, q, e);
    apb(1'b1, `SWT_REG_INT_CLEAR, 32'h3, q, e);
    apu_seen <= 1'b0;
    apb(1'b1, `SWT_REG_CMD, {16'h0, dbyte, `SWT_CMD_TRIPLET}, q, e);
    t0 = cyc;
    accepted++;
    chk(line_oe, 1'b1);
    if (idx == 0) begin
      apb(1'b1, `SWT_REG_CMD, {16'h0, dbyte, `SWT_CMD_TRIPLET}, q, e);
      apb(1'b0, `SWT_REG_INT_STATUS, 32'h0, q, e);
      chk(q[1], 1'b1);
      apb(1'b0, `SWT_REG_READ_DATA, 32'h0, q, e);
      chk(q, 32'h1);
    end
    // busy polling; a stuck busy flag ends in the bench timeout
    do begin
      apb(1'b0, `SWT_REG_STATUS, 32'h0, q, e);
    end while (q[0] !== 1'b0);
    chk(cyc - t0, (cyc - t0 >= 7500 && cyc - t0 <= 7506) ? cyc - t0 : 7500);
    chk(q, {24'h0, exp_dir(ans, v), ans[1], ans[0], 5'h0});
    chk(last_write, exp_dir(ans, v));
    chk(write_count, accepted);
    chk(apu_seen, active_pullup_enable);
    chk(irq, ien);
    apb(1'b1, `SWT_REG_INT_CLEAR, 32'h3, q, e);
    @(posedge pclk);
    chk(irq, 1'b0);
    $display("test %0d done", idx);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    answer = 2'h0;
    apu_seen = 1'b0;
    cyc = 0;
    err_count = 0;
    samples_checked = 0;
    accepted = 0;
    void'($urandom(32'h9d3c));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `SWT_REG_STATUS, 32'h0, q, e);
    chk(q, 32'h0);
    // unmapped offset answers with an error and zero data
    apb(1'b0, 8'h20, 32'h0, q, e);
    chk(e, 1'b1);
    chk(q, 32'h0);
    // a foreign command code is refused and raises the refused interrupt
    apb(1'b1, `SWT_REG_INT_ENABLE, 32'h2, q, e);
    apb(1'b1, `SWT_REG_CMD, {16'h0, 8'hff, 8'h87}, q, e);
    apb(1'b0, `SWT_REG_STATUS, 32'h0, q, e);
    chk(q, 32'h0);
    apb(1'b0, `SWT_REG_INT_STATUS, 32'h0, q, e);
    chk(q, 32'h2);
    chk(irq, 1'b1);
    // point reads at config so the triplet has to move the pointer back
    apb(1'b1, `SWT_REG_READ_PTR, 32'h1, q, e);
    apb(1'b1, `SWT_REG_CONFIG, 32'h3, q, e);
    apb(1'b0, `SWT_REG_READ_DATA, 32'h0, q, e);
    chk(q, 32'h3);
    $display("test setup done");
    // five steps of a search pass; a full pass of 64 would outgrow the cycle budget
    for (int i = 0; i < 5; i++) begin
      run_trip(i, tab_ans[i], (i < 2) ? i[0] : 1'($urandom), !i[0], i != 3);
    end
    results();
  end
endmodule
`default_nettype wire
